// file: pbg_pkg.sv
package pbg_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Clock and sample period
	localparam int CLK_PERIOD_NS = 100;
	localparam int FS_PERIOD_NS  = 20833;
	localparam int FS_CYCLES     = FS_PERIOD_NS / CLK_PERIOD_NS;
	localparam int FS_CNT_W      = 8;
	localparam logic [FS_CNT_W-1:0] FS_LAST = FS_CNT_W'(FS_CYCLES - 1);

	////////////////////////////////////////////////////////////////////////////////
	// Register indices and byte addresses
	localparam int ADDR_W = 12;
	localparam logic [7:0] IDX_STEP_CTRL = 8'h1D;
	localparam logic [7:0] IDX_HANDSET   = 8'h1E;
	localparam logic [7:0] IDX_PHONE_BUZ = 8'h1F;
	localparam logic [7:0] IDX_AGC_CTRL  = 8'h30;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int HS_MUTE_BIT       = 15;
	localparam int HS_GAIN_LSB       = 8;
	localparam int HS_TGT_LSB        = 5;
	localparam int HS_TC_LSB         = 1;
	localparam int HS_AGC_BIT        = 0;
	localparam int PB_PHONE_PD_BIT   = 15;
	localparam int PB_PHONE_GAIN_LSB = 8;
	localparam int PB_BUZ_PD_BIT     = 6;
	localparam int PB_BUZ_GAIN_LSB   = 2;
	localparam int SC_PHONE_OFF_BIT  = 12;
	localparam int SC_BUZ_OFF_BIT    = 11;
	localparam int AC_PHONE_AGC_BIT  = 0;

	////////////////////////////////////////////////////////////////////////////////
	// Reset values and gain limits
	localparam logic       HS_MUTE_RST    = 1'b1;
	localparam logic [6:0] HS_GAIN_RST    = 7'h7F;
	localparam logic [2:0] HS_TGT_RST     = 3'h0;
	localparam logic [3:0] HS_TC_RST      = 4'h0;
	localparam logic       PHONE_PD_RST   = 1'b1;
	localparam logic [6:0] PHONE_GAIN_RST = 7'h45;
	localparam logic [6:0] PHONE_GAIN_MIN = 7'h00;
	localparam logic [6:0] PHONE_GAIN_MAX = 7'h5D;
	localparam logic       BUZ_PD_RST     = 1'b1;
	localparam logic [3:0] BUZ_GAIN_RST   = 4'hF;
	localparam logic [6:0] BUZ_DB_FLOOR   = 7'h2D;
	localparam logic [1:0] RESP_OKAY      = 2'b00;
	localparam logic [1:0] RESP_SLVERR    = 2'b10;

	////////////////////////////////////////////////////////////////////////////////
	// AGC time constants in ms
	localparam logic [3:0][4:0] ATK_MS = {5'h14, 5'h10, 5'h0B, 5'h08};
	localparam logic [3:0][9:0] DCY_MS = {10'h1F4, 10'h190, 10'h0C8, 10'h064};

	function automatic logic [6:0] pbg_phone_clamp(input logic [6:0] c);
		return (c >= PHONE_GAIN_MAX) ? PHONE_GAIN_MAX : c;
	endfunction

	function automatic logic [7:0] pbg_phone_half_db(input logic [6:0] c);
		return {1'b0, c} - {1'b0, PHONE_GAIN_RST};
	endfunction

	function automatic logic [6:0] pbg_buz_db(input logic [3:0] c);
		return ({3'b000, c} + {2'b00, c, 1'b0}) - BUZ_DB_FLOOR;
	endfunction

	function automatic logic [15:0] pbg_merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		return {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction

	function automatic logic pbg_mapped(input logic [ADDR_W-1:0] a);
		logic [7:0] idx;
		idx = a[9:2];
		if (a[11:10] != 2'b00) begin
			return 1'b0;
		end else if (idx == IDX_STEP_CTRL || idx == IDX_HANDSET) begin
			return 1'b1;
		end else if (idx == IDX_PHONE_BUZ || idx == IDX_AGC_CTRL) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction

endpackage

// file: pbg_tick.sv
`timescale 1ns/10ps
module pbg_tick import pbg_pkg::*; (
	input  wire logic clk,
	input  wire logic nrst,
	output logic      tick
);

	typedef struct packed {
		logic [FS_CNT_W-1:0] cnt;
		logic                tick;
	} pbg_tick_t;

	pbg_tick_t s_r;
	pbg_tick_t s_nxt;

	// One pulse per reference sample period
	always_comb begin
		s_nxt      = s_r;
		s_nxt.tick = (s_r.cnt == FS_LAST);
		s_nxt.cnt  = (s_r.cnt == FS_LAST) ? '0 : s_r.cnt + 1'b1;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign tick = s_r.tick;

endmodule

// file: pbg_stepper.sv
`timescale 1ns/10ps
module pbg_stepper import pbg_pkg::*; #(
	parameter int           W   = 7,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         clk,
	input  wire logic         nrst,
	input  wire logic         tick,
	input  wire logic         off,
	input  wire logic [W-1:0] target,
	output logic      [W-1:0] applied,
	output logic              done
);

	typedef struct packed {
		logic [W-1:0] applied;
		logic         done;
	} pbg_step_t;

	pbg_step_t s_r;
	pbg_step_t s_nxt;

	always_comb begin
		s_nxt = s_r;
		if (off) begin
			s_nxt.applied = target;
		end else if (tick && s_r.applied < target) begin
			s_nxt.applied = s_r.applied + 1'b1;
		end else if (tick && s_r.applied > target) begin
			s_nxt.applied = s_r.applied - 1'b1;
		end
		s_nxt.done = (s_nxt.applied == target);
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_r.applied <= RST;
			s_r.done    <= 1'b0;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign applied = s_r.applied;
	assign done    = s_r.done;

	a_step_only_tick: assert property (@(posedge clk) disable iff (!nrst)
		(!tick && !off) |=> (applied == $past(applied)))
		else $error("gain moved outside a sample tick");
	a_step_one_code: assert property (@(posedge clk) disable iff (!nrst)
		(tick && !off && (target != applied)) |=> ((applied == $past(applied) + 1'b1)
		|| (applied == $past(applied) - 1'b1)))
		else $error("gain step is not one code");
	a_done_match: assert property (@(posedge clk) disable iff (!nrst)
		nrst |=> (done == (applied == $past(target))))
		else $error("completion flag disagrees with applied gain");
	a_off_direct: assert property (@(posedge clk) disable iff (!nrst)
		off |=> (applied == $past(target)) && done)
		else $error("gain not applied at once with stepping off");

endmodule

// file: pbg_gain_ctrl.sv
`timescale 1ns/10ps
// Operation
// - The handset time-constant field gives attack 8/11/16/20 ms from its low bits and decay 100/200/400/500 ms.
// - With handset AGC off the PGA takes the mute and gain fields, with it on the AGC sets the gain.
// - The phone power-down bit resets to 1, a 1 powers the phone PGA down and a 0 powers it up.
// - The phone gain code runs from -34.5 dB in 0.5 dB steps, 0 dB at its reset code, 12 dB from 1011101 up.
// - With phone AGC on, the phone gain field ignores writes and reads back the gain applied by the AGC.
// - With phone AGC off, the phone flag, reset 0, reads 1 when applied gain equals the programmed gain and 0 otherwise.
// - With phone AGC on, the phone flag reads 1 when the gain sits at its minimum or maximum.
// - The buzzer power-down bit resets to 1, a 1 powers the buzzer PGA down and a 0 powers it up.
// - The buzzer gain code, reset 1111, gives 0 dB at 1111 and 3 dB less per code down to -45 dB.
// - The buzzer flag, reset 0, reads 1 when applied gain equals the programmed gain and 0 otherwise.
// - Bit 0 of the phone and buzzer register reads 0 and software writes only 0 to it.
// - Unless stepping is off or phone AGC is on, the phone gain moves one 0.5 dB code per sample period toward its target.
// - Unless stepping is off, the buzzer gain moves one 3 dB code per sample period toward its target.
module pbg_gain_ctrl import pbg_pkg::*; (
	input  wire logic              clk,
	input  wire logic              nrst,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	input  wire logic [6:0]        handset_agc_gain,
	input  wire logic [6:0]        phone_agc_gain,
	output logic [6:0]             handset_pga_gain,
	output logic                   handset_input_mute,
	output logic                   handset_agc_on,
	output logic [2:0]             handset_agc_target,
	output logic [4:0]             handset_attack_ms,
	output logic [9:0]             handset_decay_ms,
	output logic                   phone_pga_powerdown,
	output logic [7:0]             phone_gain_half_db,
	output logic                   phone_gain_flag,
	output logic                   buzzer_pga_powerdown,
	output logic [6:0]             buzzer_gain_db,
	output logic                   buzzer_gain_flag
);

	////////////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [ADDR_W-1:0] awaddr;
		logic              aw_got;
		logic [15:0]       wdata;
		logic [1:0]        wstrb;
		logic              w_got;
		logic              awready;
		logic              wready;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              arready;
		logic              rvalid;
		logic [15:0]       rdata;
		logic [1:0]        rresp;
		logic              hs_mute;
		logic [6:0]        hs_gain;
		logic [2:0]        hs_tgt;
		logic [3:0]        hs_tc;
		logic              hs_agc;
		logic              ph_pd;
		logic [6:0]        ph_gain;
		logic              bz_pd;
		logic [3:0]        bz_gain;
		logic              ph_ss_off;
		logic              bz_ss_off;
		logic              ph_agc;
		logic [6:0]        o_hs_gain;
		logic              o_hs_mute;
		logic [4:0]        o_atk;
		logic [9:0]        o_dcy;
		logic              o_ph_pd;
		logic [7:0]        o_ph_db;
		logic              o_ph_flag;
		logic              o_bz_pd;
		logic [6:0]        o_bz_db;
		logic              o_bz_flag;
	} pbg_state_t;

	pbg_state_t  s_r;
	pbg_state_t  s_nxt;
	logic        tick;
	logic [6:0]  ph_target;
	logic        ph_off;
	logic [6:0]  ph_applied;
	logic        ph_done;
	logic [3:0]  bz_applied;
	logic        bz_done;
	logic        ph_sat;
	logic        wr_go;
	logic [7:0]  widx;
	logic [7:0]  ridx;
	logic [15:0] img_hs;
	logic [15:0] img_pb;
	logic [15:0] img_sc;
	logic [15:0] img_ac;
	logic [15:0] wv;

	////////////////////////////////////////////////////////////////////////////////
	// Sample tick and soft-steppers
	pbg_tick u_tick (
		.clk  (clk),
		.nrst (nrst),
		.tick (tick)
	);

	assign ph_target = s_r.ph_agc ? pbg_phone_clamp(phone_agc_gain) : pbg_phone_clamp(s_r.ph_gain);
	assign ph_off    = s_r.ph_ss_off | s_r.ph_agc;

	pbg_stepper #(.W(7), .RST(PHONE_GAIN_RST)) u_phone_step (
		.clk     (clk),
		.nrst    (nrst),
		.tick    (tick),
		.off     (ph_off),
		.target  (ph_target),
		.applied (ph_applied),
		.done    (ph_done)
	);

	pbg_stepper #(.W(4), .RST(BUZ_GAIN_RST)) u_buzzer_step (
		.clk     (clk),
		.nrst    (nrst),
		.tick    (tick),
		.off     (s_r.bz_ss_off),
		.target  (s_r.bz_gain),
		.applied (bz_applied),
		.done    (bz_done)
	);

	assign ph_sat = (ph_applied == PHONE_GAIN_MIN) || (ph_applied == PHONE_GAIN_MAX);

	////////////////////////////////////////////////////////////////////////////////
	// Register images
	assign img_hs = {s_r.hs_mute, s_r.hs_gain, s_r.hs_tgt, s_r.hs_tc, s_r.hs_agc};
	assign img_pb = {s_r.ph_pd, s_r.ph_gain, s_r.o_ph_flag, s_r.bz_pd, s_r.bz_gain, s_r.o_bz_flag, 1'b0};
	assign img_sc = {3'b000, s_r.ph_ss_off, s_r.bz_ss_off, 11'h000};
	assign img_ac = {15'h0000, s_r.ph_agc};
	assign widx   = s_r.awaddr[9:2];
	assign ridx   = araddr[9:2];

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		s_nxt = s_r;
		wr_go = 1'b0;
		wv    = 16'h0000;
		if (awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.awaddr = awaddr;
		end
		if (wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = wdata[15:0];
			s_nxt.wstrb = wstrb[1:0];
		end
		if (bready && s_r.bvalid) begin
			s_nxt.bvalid = 1'b0;
		end
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			wr_go        = 1'b1;
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got  = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp  = pbg_mapped(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
			if (s_r.awaddr[11:10] != 2'b00) begin
				wv = 16'h0000;
			end else if (widx == IDX_HANDSET) begin
				wv            = pbg_merge(img_hs, s_r.wdata, s_r.wstrb);
				s_nxt.hs_mute = wv[HS_MUTE_BIT];
				s_nxt.hs_gain = wv[HS_GAIN_LSB +: 7];
				s_nxt.hs_tgt  = wv[HS_TGT_LSB +: 3];
				s_nxt.hs_tc   = wv[HS_TC_LSB +: 4];
				s_nxt.hs_agc  = wv[HS_AGC_BIT];
			end else if (widx == IDX_PHONE_BUZ) begin
				wv            = pbg_merge(img_pb, s_r.wdata, s_r.wstrb);
				s_nxt.ph_pd   = wv[PB_PHONE_PD_BIT];
				s_nxt.bz_pd   = wv[PB_BUZ_PD_BIT];
				s_nxt.bz_gain = wv[PB_BUZ_GAIN_LSB +: 4];
				if (!s_r.ph_agc) begin
					s_nxt.ph_gain = wv[PB_PHONE_GAIN_LSB +: 7];
				end
			end else if (widx == IDX_STEP_CTRL) begin
				wv              = pbg_merge(img_sc, s_r.wdata, s_r.wstrb);
				s_nxt.ph_ss_off = wv[SC_PHONE_OFF_BIT];
				s_nxt.bz_ss_off = wv[SC_BUZ_OFF_BIT];
			end else if (widx == IDX_AGC_CTRL) begin
				wv           = pbg_merge(img_ac, s_r.wdata, s_r.wstrb);
				s_nxt.ph_agc = wv[AC_PHONE_AGC_BIT];
			end
		end
		if (rready && s_r.rvalid) begin
			s_nxt.rvalid = 1'b0;
		end
		if (arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp  = pbg_mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
			if (araddr[11:10] != 2'b00) begin
				s_nxt.rdata = 16'h0000;
			end else if (ridx == IDX_HANDSET) begin
				s_nxt.rdata = s_r.hs_agc ? {s_r.hs_mute, s_r.o_hs_gain, img_hs[7:0]} : img_hs;
			end else if (ridx == IDX_PHONE_BUZ) begin
				s_nxt.rdata = s_r.ph_agc ? {s_r.ph_pd, ph_applied, img_pb[7:0]} : img_pb;
			end else if (ridx == IDX_STEP_CTRL) begin
				s_nxt.rdata = img_sc;
			end else if (ridx == IDX_AGC_CTRL) begin
				s_nxt.rdata = img_ac;
			end else begin
				s_nxt.rdata = 16'h0000;
			end
		end
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready  = !s_nxt.w_got && !s_nxt.bvalid;
		s_nxt.arready = !s_nxt.rvalid;
		// Applied gains and decoded values
		s_nxt.o_hs_gain = s_r.hs_agc ? handset_agc_gain : s_r.hs_gain;
		s_nxt.o_hs_mute = s_r.hs_agc ? 1'b0 : s_r.hs_mute;
		s_nxt.o_atk     = ATK_MS[s_r.hs_tc[1:0]];
		s_nxt.o_dcy     = DCY_MS[s_r.hs_tc[3:2]];
		s_nxt.o_ph_pd   = s_r.ph_pd;
		s_nxt.o_ph_db   = pbg_phone_half_db(ph_applied);
		s_nxt.o_ph_flag = s_r.ph_agc ? ph_sat : ph_done;
		s_nxt.o_bz_pd   = s_r.bz_pd;
		s_nxt.o_bz_db   = pbg_buz_db(bz_applied);
		s_nxt.o_bz_flag = bz_done;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			s_r           <= '0;
			s_r.hs_mute   <= HS_MUTE_RST;
			s_r.hs_gain   <= HS_GAIN_RST;
			s_r.hs_tgt    <= HS_TGT_RST;
			s_r.hs_tc     <= HS_TC_RST;
			s_r.ph_pd     <= PHONE_PD_RST;
			s_r.ph_gain   <= PHONE_GAIN_RST;
			s_r.bz_pd     <= BUZ_PD_RST;
			s_r.bz_gain   <= BUZ_GAIN_RST;
			s_r.o_hs_gain <= HS_GAIN_RST;
			s_r.o_hs_mute <= HS_MUTE_RST;
			s_r.o_atk     <= ATK_MS[HS_TC_RST[1:0]];
			s_r.o_dcy     <= DCY_MS[HS_TC_RST[3:2]];
			s_r.o_ph_pd   <= PHONE_PD_RST;
			s_r.o_bz_pd   <= BUZ_PD_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign awready              = s_r.awready;
	assign wready               = s_r.wready;
	assign bvalid               = s_r.bvalid;
	assign bresp                = s_r.bresp;
	assign arready              = s_r.arready;
	assign rvalid               = s_r.rvalid;
	assign rdata                = {16'h0000, s_r.rdata};
	assign rresp                = s_r.rresp;
	assign handset_pga_gain     = s_r.o_hs_gain;
	assign handset_input_mute   = s_r.o_hs_mute;
	assign handset_agc_on       = s_r.hs_agc;
	assign handset_agc_target   = s_r.hs_tgt;
	assign handset_attack_ms    = s_r.o_atk;
	assign handset_decay_ms     = s_r.o_dcy;
	assign phone_pga_powerdown  = s_r.o_ph_pd;
	assign phone_gain_half_db   = s_r.o_ph_db;
	assign phone_gain_flag      = s_r.o_ph_flag;
	assign buzzer_pga_powerdown = s_r.o_bz_pd;
	assign buzzer_gain_db       = s_r.o_bz_db;
	assign buzzer_gain_flag     = s_r.o_bz_flag;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	a_tc_decode: assert property (@(posedge clk) disable iff (!nrst)
		1'b1 |=> (handset_attack_ms == ATK_MS[$past(s_r.hs_tc[1:0])])
		&& (handset_decay_ms == DCY_MS[$past(s_r.hs_tc[3:2])]))
		else $error("time constant decode wrong");
	a_hs_gain_src: assert property (@(posedge clk) disable iff (!nrst)
		1'b1 |=> handset_pga_gain == ($past(s_r.hs_agc) ? $past(handset_agc_gain) : $past(s_r.hs_gain)))
		else $error("handset gain source wrong");
	a_phone_pd_write: assert property (@(posedge clk) disable iff (!nrst)
		(wr_go && widx == IDX_PHONE_BUZ && s_r.wstrb[1]) |=> ##1 (phone_pga_powerdown == $past(s_r.wdata[15], 2)))
		else $error("phone power-down not taken from write");
	a_phone_range: assert property (@(posedge clk) disable iff (!nrst)
		(ph_applied <= PHONE_GAIN_MAX) && ($signed(phone_gain_half_db) <= $signed(8'h18))
		&& ($signed(phone_gain_half_db) >= $signed(8'hBB)))
		else $error("phone gain above 12 dB");
	a_phone_ro: assert property (@(posedge clk) disable iff (!nrst)
		(wr_go && s_r.ph_agc) |=> (s_r.ph_gain == $past(s_r.ph_gain)))
		else $error("phone gain written under AGC");
	a_phone_flag: assert property (@(posedge clk) disable iff (!nrst)
		!s_r.ph_agc |=> (phone_gain_flag == $past(ph_done)))
		else $error("phone completion flag wrong");
	a_phone_sat: assert property (@(posedge clk) disable iff (!nrst)
		s_r.ph_agc |=> (phone_gain_flag == $past(ph_applied == PHONE_GAIN_MIN || ph_applied == PHONE_GAIN_MAX)))
		else $error("phone saturation flag wrong");
	a_buz_pd_write: assert property (@(posedge clk) disable iff (!nrst)
		(wr_go && widx == IDX_PHONE_BUZ && s_r.wstrb[0]) |=> ##1 (buzzer_pga_powerdown == $past(s_r.wdata[6], 2)))
		else $error("buzzer power-down not taken from write");
	a_buz_db_ends: assert property (@(posedge clk) disable iff (!nrst)
		(bz_applied == 4'h0) |=> (buzzer_gain_db == 7'h53))
		else $error("buzzer floor is not -45 dB");
	a_buz_flag: assert property (@(posedge clk) disable iff (!nrst)
		1'b1 |=> (buzzer_gain_flag == $past(bz_done)))
		else $error("buzzer flag wrong");
	a_rsvd_zero: assert property (@(posedge clk) disable iff (!nrst)
		(arvalid && arready) |=> (rdata[0] == 1'b0 || $past(ridx) != IDX_PHONE_BUZ))
		else $error("reserved bit read as one");

endmodule

// file: pbg_gain_ctrl_bench.sv
`timescale 1ns/10ps
module phone_buzzer_gain_ctrl_bench import pbg_pkg::*; ;

	logic              clk, nrst, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid;
	logic [ADDR_W-1:0] awaddr, araddr;
	logic [31:0]       wdata, rdata, rd, r, seed;
	logic [3:0]        wstrb;
	logic [1:0]        bresp, rresp, rsp;
	logic [6:0]        handset_agc_gain, phone_agc_gain, handset_pga_gain, buzzer_gain_db;
	logic              handset_input_mute, handset_agc_on, phone_pga_powerdown, phone_gain_flag;
	logic              buzzer_pga_powerdown, buzzer_gain_flag;
	logic [2:0]        handset_agc_target;
	logic [4:0]        handset_attack_ms;
	logic [9:0]        handset_decay_ms;
	logic [7:0]        phone_gain_half_db;
	int                n_mismatch = 0;
	int                cmp_count  = 0;
	localparam logic [4:0] ATK_E [4] = '{5'h08, 5'h0B, 5'h10, 5'h14};
	localparam logic [9:0] DCY_E [4] = '{10'h064, 10'h0C8, 10'h190, 10'h1F4};
	localparam logic [6:0] PH_C  [4] = '{7'h00, 7'h5D, 7'h7F, 7'h45};

	pbg_gain_ctrl DUT (.clk, .nrst, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
		.bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
		.handset_agc_gain, .phone_agc_gain, .handset_pga_gain, .handset_input_mute, .handset_agc_on,
		.handset_agc_target, .handset_attack_ms, .handset_decay_ms, .phone_pga_powerdown,
		.phone_gain_half_db, .phone_gain_flag, .buzzer_pga_powerdown, .buzzer_gain_db, .buzzer_gain_flag);

	always #50 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	// Expectations and bus tasks
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic logic [7:0] ph_db(input logic [6:0] c);
		return ((c > 7'h5D) ? 8'h5D : {1'b0, c}) - 8'h45;
	endfunction

	function automatic logic [6:0] bz_db(input logic [3:0] c);
		return c * 7'h03 - 7'h2D;
	endfunction

	task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [15:0] d, input logic [1:0] e);
		logic done;
		done = 1'b0;
		@(posedge clk);
		awaddr <= a;
		wdata <= {16'h0000, d};
		wstrb <= 4'hF;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!done) begin
			@(posedge clk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid && bready) begin
				chk(bresp, e, "write response");
				done = 1'b1;
				bready <= 1'b0;
			end
		end
	endtask

	task automatic rd_reg(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] s);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid && rready));
		d = rdata;
		s = rresp;
		rready <= 1'b0;
	endtask

	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		$display("mismatch at %0t: watchdog expired", $time);
		print_verdict();
	end

	////////////////////////////////////////////////////////////////////////////////
	// Tests
	initial begin
		seed = 32'h3809_43f2;
		{clk, nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{handset_agc_gain, phone_agc_gain} = '0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		repeat (2) @(posedge clk);
		rd_reg(12'h07C, rd, rsp);
		chk(rd, 32'h0000_C5FE, "reset phone buzzer reg");
		chk({phone_gain_half_db, buzzer_gain_db}, 15'h0000, "reset gains");
		rd_reg(12'h078, rd, rsp);
		chk(rd, 32'h0000_FF00, "reset handset reg");
		wr(12'h100, 16'hFFFF, RESP_SLVERR);
		rd_reg(12'h100, rd, rsp);
		chk({rsp, rd}, {RESP_SLVERR, 32'h0000_0000}, "unmapped read");
		$display("test reset done");
		for (int t = 0; t < 16; t++) begin
			r = rnd();
			handset_agc_gain <= r[22:16];
			wr(12'h078, {r[15:5], t[3:0], r[0]}, RESP_OKAY);
			repeat (4) @(posedge clk);
			chk({handset_attack_ms, handset_decay_ms, handset_agc_target},
				{ATK_E[t[1:0]], DCY_E[t[3:2]], r[7:5]}, "time const");
			chk({handset_agc_on, handset_input_mute, handset_pga_gain},
				r[0] ? {2'b10, r[22:16]} : {1'b0, r[15:8]}, "handset gain");
		end
		$display("test handset done");
		wr(12'h074, 16'h1800, RESP_OKAY);
		for (int i = 0; i < 8; i++) begin
			r = rnd();
			r[14:8] = (i < 4) ? PH_C[i] : r[14:8];
			if (i < 2) r[5:2] = {4{i[0]}};
			wr(12'h07C, {r[15:2], 2'b00}, RESP_OKAY);
			repeat (4) @(posedge clk);
			chk({phone_pga_powerdown, phone_gain_half_db, phone_gain_flag},
				{r[15], ph_db(r[14:8]), 1'b1}, "phone gain");
			chk({buzzer_pga_powerdown, buzzer_gain_db, buzzer_gain_flag},
				{r[6], bz_db(r[5:2]), 1'b1}, "buzzer gain");
			rd_reg(12'h07C, rd, rsp);
			chk({rsp, rd}, {RESP_OKAY, 16'h0000, r[15:8], 1'b1, r[6:2], 2'b10}, "readback");
		end
		$display("test direct gain done");
		wr(12'h07C, 16'h1020, RESP_OKAY);
		repeat (4) @(posedge clk);
		wr(12'h074, 16'h0000, RESP_OKAY);
		wr(12'h07C, 16'h1318, RESP_OKAY);
		repeat (5) @(posedge clk);
		chk({phone_gain_flag, buzzer_gain_flag}, 2'b00, "flags while stepping");
		repeat (FS_CYCLES * 2 - 10) @(posedge clk);
		chk(phone_gain_flag, 1'b0, "phone step rate");
		repeat (FS_CYCLES * 2) @(posedge clk);
		chk({phone_gain_flag, phone_gain_half_db}, {1'b1, ph_db(7'h13)}, "phone stepped");
		chk({buzzer_gain_flag, buzzer_gain_db}, {1'b1, bz_db(4'h6)}, "buzzer stepped");
		$display("test stepping done");
		wr(12'h0C0, 16'h0001, RESP_OKAY);
		for (int i = 0; i < 6; i++) begin
			r = rnd();
			r[6:0] = (i < 4) ? PH_C[i] : r[6:0];
			phone_agc_gain <= r[6:0];
			wr(12'h07C, {1'b0, r[14:8], 8'h3C}, RESP_OKAY);
			repeat (4) @(posedge clk);
			chk({phone_gain_half_db, phone_gain_flag},
				{ph_db(r[6:0]), (r[6:0] == 7'h00 || r[6:0] >= 7'h5D)}, "agc gain");
			rd_reg(12'h07C, rd, rsp);
			chk(rd[14:8], (r[6:0] > 7'h5D) ? 7'h5D : r[6:0], "agc readback");
		end
		$display("test phone agc done");
		print_verdict();
	end

endmodule
